/* src/rsf_pkg.sv */
// Constants shared by the reset source filter: timing counts, flag and field positions.
// Assumes a 100 MHz system clock feeding the filter logic.
package rsf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_FREQ_MHZ     = 100;
  localparam int          EXT_FILTER_US    = 36;
  localparam logic [11:0] EXT_FILTER_CYC   = 12'(EXT_FILTER_US * CLK_FREQ_MHZ);
  localparam logic [11:0] LVR_DEGLITCH_CYC = 12'h0010;
  localparam logic [11:0] BOD_DEGLITCH_CYC = 12'h0014;
  localparam logic [1:0]  BOD_LOW_SPEED_INTERNAL_OSC_EDGES   = 2'h2;
  localparam logic [11:0] FILT_CNT_MAX     = 12'hfff;

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  localparam int         CAUSE_W          = 9;
  localparam int         CAUSE_POR_BIT    = 0;
  localparam int         CAUSE_PIN_BIT    = 1;
  localparam int         CAUSE_WDT_BIT    = 2;
  localparam int         CAUSE_BOD_BIT    = 4;
  localparam int         CAUSE_LOCKUP_BIT = 8;
  localparam logic [8:0] CAUSE_RST_VAL    = 9'h001;

  // ----------------------------------------------------------------
  // Brown-out control register and its flash defaults
  // ----------------------------------------------------------------
  localparam int         BODCTL_W        = 4;
  localparam int         BOD_EN_BIT      = 0;
  localparam int         BOD_LVL_LSB     = 1;
  localparam int         BOD_RSTEN_BIT   = 3;
  localparam logic [3:0] BODCTL_RST_VAL  = 4'h0;
  localparam int         CFG_BOD_EN_BIT  = 23;
  localparam int         CFG_BOD_LVL_LSB = 21;
  localparam int         CFG_BOD_RST_BIT = 20;

endpackage

/* src/rsf_reset_filter.sv */
// Reset source filter: deglitches pin, low-voltage and brown-out sources, records the cause.
// Assumes analog detector outputs, the slow oscillator and the pin are asynchronous; other inputs are on sys_clk_i.
//
// Contract
// - Pin low must persist over 36 us before chip reset asserts.
// - After pin reset, pin high must persist over 36 us before release.
// - Pin reset sets cause bit 1.
// - Reset held while power-on detector says supply not ready.
// - Power-on event sets cause bit 0.
// - Writing 1 clears power-on flag; writing 0 leaves it.
// - Low-voltage reset asserts after undervoltage persists over 16 clocks.
// - Low-voltage release needs good voltage over 16 clocks.
// - Brown-out monitored for reset only while enable bit 0 set.
// - Threshold chosen by enable bit and level field bits 2:1.
// - Brown-out reset after over max of 20 clocks and one slow-oscillator cycle.
// - Brown-out release needs good supply for the same deglitch time.
// - Brown-out enable, level, reset enable load from config bits 23, 22:21, 20.
// - Watchdog time-out reset recorded in its own cause flag.
// - Processor lockup ignored as reset source in debug mode.
`timescale 1ns/1ps
`default_nettype none

module rsf_reset_filter
  import rsf_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic                ext_reset_pin_n_i,
  input  wire logic                por_ready_i,
  input  wire logic                lvr_low_i,
  input  wire logic                bod_low_i,
  input  wire logic                low_speed_internal_osc_clk_i,
  input  wire logic [31:0]         flash_config_word_i,
  input  wire logic                watchdog_timeout_i,
  input  wire logic                lockup_i,
  input  wire logic                debug_mode_i,
  input  wire logic                whole_chip_reset_request_i,
  input  wire logic [CAUSE_W-1:0]  cause_clear_i,
  input  wire logic                bodctl_wr_i,
  input  wire logic [BODCTL_W-1:0] bodctl_wdata_i,
  output logic                     chip_reset_o,
  output logic [CAUSE_W-1:0]       reset_cause_register_o,
  output logic [BODCTL_W-1:0]      brownout_control_register_o
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Order: 0 pin, 1 por ready, 2 lvr, 3 bod, 4 slow oscillator
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       low_speed_internal_osc_prev;
  logic [4:0] next_sync1;
  logic [4:0] next_sync2;
  logic       next_low_speed_internal_osc_prev;

  always_comb
  begin
    next_sync1     = {low_speed_internal_osc_clk_i, bod_low_i, lvr_low_i, por_ready_i, ext_reset_pin_n_i};
    next_sync2     = sync1;
    next_low_speed_internal_osc_prev = sync2[4];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // Pin and supply idle-good values avoid a spurious reset on release
      sync1     <= 5'h03;
      sync2     <= 5'h03;
      low_speed_internal_osc_prev <= 1'b0;
    end
    else
    begin
      sync1     <= next_sync1;
      sync2     <= next_sync2;
      low_speed_internal_osc_prev <= next_low_speed_internal_osc_prev;
    end
  end

  logic por_hold;
  logic low_speed_internal_osc_rise;
  logic lockup_eff;
  logic bod_mon;

  assign por_hold   = ~sync2[1];
  assign low_speed_internal_osc_rise  = sync2[4] & ~low_speed_internal_osc_prev;
  assign lockup_eff = lockup_i & ~debug_mode_i;
  assign bod_mon    = brownout_control_register_o[BOD_EN_BIT] &
                      brownout_control_register_o[BOD_RSTEN_BIT];

  // ----------------------------------------------------------------
  // Deglitch filters
  // ----------------------------------------------------------------
  // Index: 0 pin, 1 low voltage, 2 brown-out
  logic [2:0]  filt_raw;
  logic [2:0]  filt_act;
  logic [11:0] filt_cnt      [3];
  logic [11:0] filt_lim      [3];
  logic [1:0]  low_speed_internal_osc_cnt;
  logic [2:0]  next_filt_act;
  logic [11:0] next_filt_cnt [3];
  logic [1:0]  next_low_speed_internal_osc_cnt;
  logic        bod_slow_ok;

  assign filt_raw    = {sync2[3] & bod_mon, sync2[2], ~sync2[0]};
  assign filt_lim[0] = EXT_FILTER_CYC;
  assign filt_lim[1] = LVR_DEGLITCH_CYC;
  assign filt_lim[2] = BOD_DEGLITCH_CYC;
  assign bod_slow_ok = (low_speed_internal_osc_cnt >= BOD_LOW_SPEED_INTERNAL_OSC_EDGES);

  always_comb
  begin
    next_filt_act = filt_act;
    for (int i = 0; i < 3; i++)
    begin
      next_filt_cnt[i] = filt_cnt[i];
      if (filt_raw[i] != filt_act[i])
      begin
        // Toggle only after the level differed for limit+1 samples
        if ((filt_cnt[i] >= filt_lim[i]) && ((i != 2) || bod_slow_ok))
        begin
          next_filt_act[i] = filt_raw[i];
          next_filt_cnt[i] = 12'h0000;
        end
        else if (filt_cnt[i] != FILT_CNT_MAX)
        begin
          next_filt_cnt[i] = filt_cnt[i] + 12'h0001;
        end
      end
      else
      begin
        next_filt_cnt[i] = 12'h0000;
      end
    end
    next_low_speed_internal_osc_cnt = low_speed_internal_osc_cnt;
    if (filt_raw[2] == filt_act[2])
    begin
      next_low_speed_internal_osc_cnt = 2'h0;
    end
    else if (low_speed_internal_osc_rise && (low_speed_internal_osc_cnt != 2'h3))
    begin
      next_low_speed_internal_osc_cnt = low_speed_internal_osc_cnt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      filt_act <= 3'h0;
      low_speed_internal_osc_cnt <= 2'h0;
      for (int i = 0; i < 3; i++)
      begin
        filt_cnt[i] <= 12'h0000;
      end
    end
    else
    begin
      filt_act <= next_filt_act;
      low_speed_internal_osc_cnt <= next_low_speed_internal_osc_cnt;
      for (int i = 0; i < 3; i++)
      begin
        filt_cnt[i] <= next_filt_cnt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Chip reset, cause flags, brown-out control
  // ----------------------------------------------------------------
  logic [CAUSE_W-1:0]  cause_set;
  logic                cfg_pending;
  logic                reload;
  logic                next_chip_reset;
  logic [CAUSE_W-1:0]  next_cause;
  logic [BODCTL_W-1:0] next_bodctl;
  logic                next_cfg_pending;

  // Brown-out reset alone keeps software's brown-out settings
  assign reload = cfg_pending | por_hold | filt_act[0] | filt_act[1] |
                  watchdog_timeout_i | lockup_eff | whole_chip_reset_request_i;

  always_comb
  begin
    cause_set                   = '0;
    cause_set[CAUSE_POR_BIT]    = por_hold | filt_act[1] |
                                  whole_chip_reset_request_i;
    cause_set[CAUSE_PIN_BIT]    = filt_act[0];
    cause_set[CAUSE_WDT_BIT]    = watchdog_timeout_i;
    cause_set[CAUSE_BOD_BIT]    = filt_act[2];
    cause_set[CAUSE_LOCKUP_BIT] = lockup_eff;
    // Set wins over a simultaneous clear
    next_cause       = (reset_cause_register_o & ~cause_clear_i) | cause_set;
    next_chip_reset  = por_hold | (|filt_act) | watchdog_timeout_i |
                       lockup_eff | whole_chip_reset_request_i;
    next_cfg_pending = 1'b0;
    next_bodctl      = brownout_control_register_o;
    if (reload)
    begin
      next_bodctl[BOD_EN_BIT]                  = flash_config_word_i[CFG_BOD_EN_BIT];
      next_bodctl[BOD_LVL_LSB+1:BOD_LVL_LSB]   = flash_config_word_i[CFG_BOD_LVL_LSB+1:CFG_BOD_LVL_LSB];
      next_bodctl[BOD_RSTEN_BIT]               = flash_config_word_i[CFG_BOD_RST_BIT];
    end
    else if (bodctl_wr_i)
    begin
      next_bodctl = bodctl_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chip_reset_o                <= 1'b1;
      reset_cause_register_o      <= CAUSE_RST_VAL;
      brownout_control_register_o <= BODCTL_RST_VAL;
      cfg_pending                 <= 1'b1;
    end
    else
    begin
      chip_reset_o                <= next_chip_reset;
      reset_cause_register_o      <= next_cause;
      brownout_control_register_o <= next_bodctl;
      cfg_pending                 <= next_cfg_pending;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_pin_enter;
    $rose(filt_act[0]);
  endsequence

  sequence s_pin_leave;
    $fell(filt_act[0]);
  endsequence

  AST_PIN_LOW_TIME: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_pin_enter |-> ($past(filt_cnt[0]) == EXT_FILTER_CYC) ##1 chip_reset_o)
    else $error("pin reset asserted without full low time");

  AST_PIN_HIGH_TIME: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_pin_leave |-> $past(filt_cnt[0]) == EXT_FILTER_CYC)
    else $error("pin reset released without full high time");

  AST_PIN_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_pin_enter |=> reset_cause_register_o[CAUSE_PIN_BIT])
    else $error("pin flag not set");

  AST_POR_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    por_hold [*2] |=> chip_reset_o)
    else $error("chip not held during power-on");

  AST_POR_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(por_hold) |=> reset_cause_register_o[CAUSE_POR_BIT])
    else $error("power-on flag not set");

  AST_POR_W1C: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cause_clear_i[CAUSE_POR_BIT] && !cause_set[CAUSE_POR_BIT] |=> !reset_cause_register_o[CAUSE_POR_BIT])
    else $error("power-on flag not cleared by write of one");

  AST_LVR_ENTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(filt_act[1]) |-> $past(filt_cnt[1]) == LVR_DEGLITCH_CYC ##1 chip_reset_o)
    else $error("low-voltage reset without deglitch time");

  AST_LVR_LEAVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(filt_act[1]) |-> $past(filt_cnt[1]) == LVR_DEGLITCH_CYC)
    else $error("low-voltage release without deglitch time");

  AST_BOD_GATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !brownout_control_register_o[BOD_EN_BIT] |-> !filt_raw[2])
    else $error("brown-out monitored while disabled");

  AST_BOD_CTL_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bodctl_wr_i && !reload |=> brownout_control_register_o == $past(bodctl_wdata_i))
    else $error("brown-out control write lost");

  AST_BOD_ENTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(filt_act[2]) |-> ($past(filt_cnt[2]) >= BOD_DEGLITCH_CYC) && ($past(low_speed_internal_osc_cnt) >= BOD_LOW_SPEED_INTERNAL_OSC_EDGES))
    else $error("brown-out reset before deglitch time");

  AST_BOD_LEAVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(filt_act[2]) |-> $past(filt_cnt[2]) >= BOD_DEGLITCH_CYC)
    else $error("brown-out release before deglitch time");

  AST_CFG_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reload |=> brownout_control_register_o ==
      {$past(flash_config_word_i[CFG_BOD_RST_BIT]), $past(flash_config_word_i[CFG_BOD_EN_BIT-1:CFG_BOD_RST_BIT+1]),
       $past(flash_config_word_i[CFG_BOD_EN_BIT])})
    else $error("brown-out defaults not loaded");

  AST_CHIP_REQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    whole_chip_reset_request_i |=> chip_reset_o)
    else $error("whole-chip request did not reset");

  AST_WDT_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    watchdog_timeout_i |=> reset_cause_register_o[CAUSE_WDT_BIT] && chip_reset_o)
    else $error("watchdog flag not set");

  AST_LOCKUP_DEBUG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lockup_i && debug_mode_i && !reset_cause_register_o[CAUSE_LOCKUP_BIT] |=>
      !reset_cause_register_o[CAUSE_LOCKUP_BIT])
    else $error("lockup honoured in debug mode");

  AST_FLAG_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reset_cause_register_o[CAUSE_PIN_BIT] && !cause_clear_i[CAUSE_PIN_BIT] |=>
      reset_cause_register_o[CAUSE_PIN_BIT])
    else $error("pin flag lost");

  AST_FILT_RESTART: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (filt_raw[1] == filt_act[1]) |=> filt_cnt[1] == 12'h0000)
    else $error("deglitch counter not restarted");

endmodule

`default_nettype wire

/* tb/rsf_analog_model.sv */
// Far-side model: reset pin, supply detectors and the slow internal oscillator.
// Assumes the bench commands each level; the oscillator runs free, as a real one does.
`timescale 1ns/1ps
`default_nettype none

module rsf_analog_model #(
  parameter int LOW_SPEED_INTERNAL_OSC_HALF_NS = 300
) (
  input  wire logic pin_low_cmd_i,
  input  wire logic supply_ok_cmd_i,
  input  wire logic lvr_cmd_i,
  input  wire logic bod_cmd_i,
  output logic      ext_reset_pin_n_o,
  output logic      por_ready_o,
  output logic      lvr_low_o,
  output logic      bod_low_o,
  output logic      low_speed_internal_osc_clk_o
);
  // ----------------------------------------------------------------
  // Detector outputs
  // ----------------------------------------------------------------
  // Short slow period keeps runs brief; one slow cycle still outlasts 20 clocks
  assign ext_reset_pin_n_o = ~pin_low_cmd_i;
  assign por_ready_o       = supply_ok_cmd_i;
  assign lvr_low_o         = lvr_cmd_i;
  assign bod_low_o         = bod_cmd_i;

  initial low_speed_internal_osc_clk_o = 1'b0;
  always #(LOW_SPEED_INTERNAL_OSC_HALF_NS) low_speed_internal_osc_clk_o = ~low_speed_internal_osc_clk_o;
endmodule

`default_nettype wire

/* tb/rsf_reset_filter_test.sv */
// Testbench for the reset source filter: filters, cause flags, brown-out control.
// Assumes a 100 MHz clock and the analog model for pin and detector levels.
`timescale 1ns/1ps
`default_nettype none

module rsf_reset_filter_test;
  import rsf_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, pin_low = 1'b0, sup_ok = 1'b1, low_voltage_reset = 1'b0, brownout_detector = 1'b0;
  logic wdt = 1'b0, lockup = 1'b0, dbg = 1'b0, chip_req = 1'b0, bod_wr = 1'b0;
  logic [CAUSE_W-1:0] cclr = '0;
  logic [BODCTL_W-1:0] bod_d = '0;
  logic [31:0] cfg = 32'h00d0_0000;
  wire logic pin_n, por_rdy, lvr_low, bod_low, low_speed_internal_osc;
  logic chip_reset_o;
  logic [CAUSE_W-1:0] cause;
  logic [BODCTL_W-1:0] bodctl;
  int bad_count = 0, total_checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  rsf_analog_model model (.pin_low_cmd_i(pin_low), .supply_ok_cmd_i(sup_ok), .lvr_cmd_i(low_voltage_reset),
    .bod_cmd_i(brownout_detector), .ext_reset_pin_n_o(pin_n), .por_ready_o(por_rdy), .lvr_low_o(lvr_low),
    .bod_low_o(bod_low), .low_speed_internal_osc_clk_o(low_speed_internal_osc));

  rsf_reset_filter uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ext_reset_pin_n_i(pin_n),
    .por_ready_i(por_rdy), .lvr_low_i(lvr_low), .bod_low_i(bod_low), .low_speed_internal_osc_clk_i(low_speed_internal_osc),
    .flash_config_word_i(cfg), .watchdog_timeout_i(wdt), .lockup_i(lockup), .debug_mode_i(dbg),
    .whole_chip_reset_request_i(chip_req), .cause_clear_i(cclr), .bodctl_wr_i(bod_wr),
    .bodctl_wdata_i(bod_d), .chip_reset_o(chip_reset_o), .reset_cause_register_o(cause),
    .brownout_control_register_o(bodctl));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cycles until chip reset shows v must fall in [lo, hi)
  task automatic wait_reset(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (chip_reset_o !== v && n < hi)
    begin
      tick(1);
      n++;
    end
    total_checks++;
    if (n < lo || n >= hi)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, n, lo);
      if (n >= hi)
        wrap_up();
    end
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      tick(1);
      seen = seen | (chip_reset_o !== 1'b0);
    end
    chk({11'h0, seen}, 12'h000);
  endtask

  task automatic clear(input logic [CAUSE_W-1:0] m);
    cclr = m;
    tick(1);
    cclr = '0;
    tick(1);
  endtask

  task automatic bod_write(input logic [BODCTL_W-1:0] d);
    bod_d = d;
    bod_wr = 1'b1;
    tick(1);
    bod_wr = 1'b0;
    chk({8'h0, bodctl}, {8'h0, d});
    tick(1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    tick(3);
    rst_i = 1'b0;
    tick(2);
    chk({8'h0, bodctl}, 12'h00d);
    chk({3'h0, cause}, 12'h001);
    wait_reset(1'b0, 0, 8);
    clear(9'h1fe);
    chk({3'h0, cause}, 12'h001);
    clear(9'h001);
    chk({3'h0, cause}, 12'h000);
    sup_ok = 1'b0;
    wait_reset(1'b1, 1, 6);
    tick(3);
    sup_ok = 1'b1;
    wait_reset(1'b0, 1, 8);
    chk({3'h0, cause}, 12'h001);
    clear(9'h1ff);
    // Glitch one sample short of the filter must be ignored
    pin_low = 1'b1;
    tick(3600);
    pin_low = 1'b0;
    quiet(40);
    pin_low = 1'b1;
    wait_reset(1'b1, 3600, 3612);
    chk({3'h0, cause}, 12'h002);
    pin_low = 1'b0;
    tick(3600);
    pin_low = 1'b1;
    tick(40);
    chk({11'h0, chip_reset_o}, 12'h001);
    pin_low = 1'b0;
    wait_reset(1'b0, 3600, 3612);
    low_voltage_reset = 1'b1;
    tick(16);
    low_voltage_reset = 1'b0;
    quiet(30);
    low_voltage_reset = 1'b1;
    wait_reset(1'b1, 16, 24);
    chk({3'h0, cause}, 12'h003);
    low_voltage_reset = 1'b0;
    wait_reset(1'b0, 16, 24);
    for (int l = 0; l < 4; l++)
      bod_write({1'b1, 2'(l), 1'b1});
    brownout_detector = 1'b1;
    wait_reset(1'b1, 20, 140);
    chk({3'h0, cause}, 12'h013);
    brownout_detector = 1'b0;
    wait_reset(1'b0, 20, 140);
    chk({8'h0, bodctl}, 12'h00f);
    // Reset enable set, monitor enable clear: still no brown-out reset
    bod_write(4'ha);
    brownout_detector = 1'b1;
    quiet(200);
    brownout_detector = 1'b0;
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    tick(3);
    chk({3'h0, cause}, 12'h017);
    chk({8'h0, bodctl}, 12'h00d);
    wait_reset(1'b0, 0, 8);
    dbg = 1'b1;
    lockup = 1'b1;
    tick(3);
    lockup = 1'b0;
    tick(1);
    dbg = 1'b0;
    tick(2);
    chk({3'h0, cause}, 12'h017);
    chk({11'h0, chip_reset_o}, 12'h000);
    lockup = 1'b1;
    tick(1);
    lockup = 1'b0;
    tick(2);
    chk({3'h0, cause}, 12'h117);
    wait_reset(1'b0, 0, 8);
    clear(9'h1ff);
    chip_req = 1'b1;
    wait_reset(1'b1, 0, 5);
    tick(5);
    chk({11'h0, chip_reset_o}, 12'h001);
    chip_req = 1'b0;
    wait_reset(1'b0, 0, 6);
    chk({3'h0, cause}, 12'h001);
    // Second reset in mid-run, with other config defaults
    bod_write(4'h0);
    clear(9'h1ff);
    cfg = 32'h0030_0000;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(2);
    chk({3'h0, cause}, 12'h001);
    chk({8'h0, bodctl}, 12'h00a);
    chk({11'h0, chip_reset_o}, 12'h000);
    wrap_up();
  end
endmodule

`default_nettype wire
